// ---- ldiag_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----
// Host model: APB master and enable pin.
// ----
module ldiag_host (
	input  wire logic        pclk,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic [31:0] prdata,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata,
	output logic             sleep_control_pin
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		sleep_control_pin = 1'b1;
	end

	// Released lines show the inverse of the last value.
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= ~w;
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer

	// The low period stays well inside the reset window.
	task automatic sleep_pulse(input int n);
		@(posedge pclk);
		sleep_control_pin <= 1'b0;
		repeat (n) @(posedge pclk);
		sleep_control_pin <= 1'b1;
	endtask : sleep_pulse
endmodule : ldiag_host
`default_nettype wire

// ---- ldiag_pkg.sv ----
`default_nettype none
package ldiag_pkg;

	// ----------------------------------------------------------------
	// Timing.
	// ----------------------------------------------------------------
	localparam int CLK_MHZ        = 100;
	localparam int DLY0_US        = 250;
	localparam int DLY1_US        = 1250;
	localparam int DLY2_US        = 5000;
	localparam int DLY3_US        = 11500;
	localparam int HW_SHORT_US    = 2000;
	localparam int RST_WINDOW_US  = 20;
	localparam int RST_WINDOW_CYC = RST_WINDOW_US * CLK_MHZ;
	localparam int TMR_W          = 21;
	localparam int CNT_W          = 12;
	localparam int FAIL_LIMIT     = 3;

	// ----------------------------------------------------------------
	// Register map.
	// ----------------------------------------------------------------
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] STAT_OFS = 12'h004;

	localparam int CTRL_PT_START  = 0;
	localparam int CTRL_SH_START  = 1;
	localparam int CTRL_CLEAR     = 2;
	localparam int CTRL_RECOV     = 3;
	localparam int CTRL_DLY_LSB   = 4;
	localparam int CTRL_ACT_LSB   = 6;

	localparam int STAT_FAULT     = 0;
	localparam int STAT_OPEN_SH   = 1;
	localparam int STAT_OPEN_SUM  = 2;
	localparam int STAT_THERM     = 3;
	localparam int STAT_OL_LSB    = 4;
	localparam int STAT_SUP_LSB   = 7;
	localparam int STAT_GND_LSB   = 10;
	localparam int STAT_BUSY      = 13;
	localparam int STAT_BLOCK     = 14;

	localparam logic [1:0] DLY_RESET = 2'h0;

	// ----------------------------------------------------------------
	// Sequencer states.
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_IDLE     = 5'h01,
		ST_SUPPLY   = 5'h02,
		ST_GROUND   = 5'h04,
		ST_PULLUP   = 5'h08,
		ST_PULLDOWN = 5'h10
	} ldiag_state_e;

endpackage : ldiag_pkg
`default_nettype wire

// ---- ldiag_top.sv ----
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ldiag_top #(
	parameter int DLY0_CYC  = ldiag_pkg::DLY0_US * ldiag_pkg::CLK_MHZ,
	parameter int DLY1_CYC  = ldiag_pkg::DLY1_US * ldiag_pkg::CLK_MHZ,
	parameter int DLY2_CYC  = ldiag_pkg::DLY2_US * ldiag_pkg::CLK_MHZ,
	parameter int DLY3_CYC  = ldiag_pkg::DLY3_US * ldiag_pkg::CLK_MHZ,
	parameter int HW_SH_CYC = ldiag_pkg::HW_SHORT_US * ldiag_pkg::CLK_MHZ
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        hw_variant_strap,
	input  wire logic        sleep_control_pin,
	input  wire logic        diag_strap_pin,
	input  wire logic        thermal_cmp,
	input  wire logic [2:0]  pullup_open_comparator,
	input  wire logic [2:0]  pulldown_open_comparator,
	input  wire logic [2:0]  overshoot_cmp,
	input  wire logic [2:0]  supply_short_cmp,
	input  wire logic [2:0]  ground_short_cmp,
	input  wire logic [2:0]  low_side_off,
	input  wire logic [2:0]  high_side_on,
	input  wire logic        pwm_input_change,
	output logic             fault_out_n,
	output logic             gates_off,
	output logic             charge_pump_en,
	output logic      [2:0]  pullup_src_en,
	output logic      [2:0]  pulldown_src_en,
	output logic      [2:0]  drain_pulldown_en
);

	localparam int TW = ldiag_pkg::TMR_W;
	localparam int CW = ldiag_pkg::CNT_W;
	localparam logic [CW-1:0] RST_WIN = CW'(ldiag_pkg::RST_WINDOW_CYC);
	localparam logic [1:0]    FAIL_LAST = 2'(ldiag_pkg::FAIL_LIMIT - 1);

	// ----------------------------------------------------------------
	// Input synchroniser.
	// ----------------------------------------------------------------
	logic [18:0] async_in;
	logic [18:0] meta_q;
	logic [18:0] sync_q;

	assign async_in = {hw_variant_strap, sleep_control_pin, diag_strap_pin, thermal_cmp,
		pullup_open_comparator, pulldown_open_comparator, overshoot_cmp, supply_short_cmp, ground_short_cmp};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= 19'h00000;
			sync_q <= 19'h00000;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	logic       hw_mode;
	logic       awake;
	logic       strap_hi;
	logic       hot;
	logic [2:0] pu_s;
	logic [2:0] pd_s;
	logic [2:0] ovs_s;
	logic [2:0] sup_s;
	logic [2:0] gnd_s;

	assign hw_mode  = sync_q[18];
	assign awake    = sync_q[17];
	assign strap_hi = sync_q[16];
	assign hot      = sync_q[15];
	assign pu_s     = sync_q[14:12];
	assign pd_s     = sync_q[11:9];
	assign ovs_s    = sync_q[8:6];
	assign sup_s    = sync_q[5:3];
	assign gnd_s    = sync_q[2:0];

	// ----------------------------------------------------------------
	// Enable pin: reset pulse and wake detection.
	// ----------------------------------------------------------------
	logic          awake_prev_q;
	logic [CW-1:0] low_cnt_q;
	logic          rise;
	logic          rst_pulse;
	logic          wake;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			awake_prev_q <= 1'b0;
			low_cnt_q    <= RST_WIN;
		end else begin
			awake_prev_q <= awake;
			if (awake) begin
				low_cnt_q <= '0;
			end else if (low_cnt_q != RST_WIN) begin
				low_cnt_q <= low_cnt_q + 1'b1;
			end
		end
	end

	assign rise      = awake & ~awake_prev_q;
	assign rst_pulse = rise & (low_cnt_q < RST_WIN);
	assign wake      = rise & ~rst_pulse;

	// ----------------------------------------------------------------
	// APB slave.
	// ----------------------------------------------------------------
	logic        pready_q;
	logic [31:0] prdata_q;
	logic        pslverr_q;
	logic        setup;
	logic        wr_ctrl;
	logic        hit;
	logic [31:0] rd_mux;

	assign setup   = psel & ~penable;
	assign wr_ctrl = psel & penable & pready_q & pwrite & (paddr == ldiag_pkg::CTRL_OFS);
	assign hit     = (paddr == ldiag_pkg::CTRL_OFS) | (paddr == ldiag_pkg::STAT_OFS);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup & ~hit;
			if (setup) begin
				prdata_q <= (pwrite | ~hit) ? 32'h00000000 : rd_mux;
			end
		end
	end

	assign pready  = pready_q;
	assign prdata  = prdata_q;
	assign pslverr = pslverr_q;

	// ----------------------------------------------------------------
	// Control register.
	// ----------------------------------------------------------------
	logic       pt_start_q;
	logic       sh_start_q;
	logic       recov_auto_q;
	logic [1:0] dly_sel_q;
	logic [2:0] act_en_q;
	logic       clr;
	logic       auto_eff;

	ldiag_pkg::ldiag_state_e state_q;
	ldiag_pkg::ldiag_state_e state_d;
	logic [TW-1:0]           tmr_q;
	logic                    tmr_done;
	logic                    pt_abort;
	logic                    pt_ok;
	logic                    sh_finish;

	assign clr      = (wr_ctrl & pwdata[ldiag_pkg::CTRL_CLEAR]) | rst_pulse | wake;
	assign auto_eff = hw_mode | recov_auto_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			recov_auto_q <= 1'b0;
			dly_sel_q    <= ldiag_pkg::DLY_RESET;
			act_en_q     <= 3'h0;
		end else if (wr_ctrl) begin
			recov_auto_q <= pwdata[ldiag_pkg::CTRL_RECOV];
			dly_sel_q    <= pwdata[ldiag_pkg::CTRL_DLY_LSB +: 2];
			act_en_q     <= pwdata[ldiag_pkg::CTRL_ACT_LSB +: 3];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pt_start_q <= 1'b0;
			sh_start_q <= 1'b0;
		end else begin
			if (wr_ctrl & ~hw_mode) begin
				pt_start_q <= pwdata[ldiag_pkg::CTRL_PT_START];
			end else if (pt_ok | pt_abort) begin
				pt_start_q <= 1'b0;
			end
			if (wr_ctrl & ~hw_mode & pwdata[ldiag_pkg::CTRL_SH_START]) begin
				sh_start_q <= 1'b1;
			end else if (sh_finish) begin
				sh_start_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Diagnostic sequencer.
	// ----------------------------------------------------------------
	function automatic logic [TW-1:0] dur_f(input logic hw, input logic [1:0] sel, input logic sh);
		logic [TW-1:0] d;
		d = TW'(DLY0_CYC);
		case (sel)
			2'h1:    d = TW'(DLY1_CYC);
			2'h2:    d = TW'(DLY2_CYC);
			2'h3:    d = TW'(DLY3_CYC);
			default: d = TW'(DLY0_CYC);
		endcase
		if (hw & sh) begin
			d = TW'(HW_SH_CYC);
		end
		dur_f = d;
	endfunction : dur_f

	logic sh_pend_q;
	logic pt_pend_q;
	logic hw_diag;
	logic [2:0] pu_open_q;
	logic [2:0] pt_set;

	assign hw_diag   = hw_mode & wake & ~strap_hi;
	assign tmr_done  = (tmr_q == '0);
	assign pt_abort  = ((state_q == ldiag_pkg::ST_PULLUP) | (state_q == ldiag_pkg::ST_PULLDOWN))
		& (pwm_input_change | (~hw_mode & ~pt_start_q));
	assign pt_set    = {3{(state_q == ldiag_pkg::ST_PULLDOWN) & tmr_done & ~pt_abort}} & pu_open_q & pd_s;
	assign pt_ok     = (state_q == ldiag_pkg::ST_PULLDOWN) & tmr_done & ~pt_abort & (pt_set == 3'h0);
	assign sh_finish = ((state_q == ldiag_pkg::ST_SUPPLY) & (state_d == ldiag_pkg::ST_IDLE))
		| ((state_q == ldiag_pkg::ST_GROUND) & (state_d != ldiag_pkg::ST_GROUND));

	always_comb begin
		state_d = state_q;
		case (state_q)
			ldiag_pkg::ST_IDLE: begin
				if (sh_pend_q) begin
					state_d = ldiag_pkg::ST_SUPPLY;
				end else if (pt_pend_q) begin
					state_d = ldiag_pkg::ST_PULLUP;
				end
			end
			ldiag_pkg::ST_SUPPLY: begin
				if (tmr_done) begin
					state_d = (sup_s != 3'h0) ? ldiag_pkg::ST_IDLE : ldiag_pkg::ST_GROUND;
				end
			end
			ldiag_pkg::ST_GROUND: begin
				if (tmr_done) begin
					state_d = (gnd_s == 3'h0 && pt_pend_q) ? ldiag_pkg::ST_PULLUP : ldiag_pkg::ST_IDLE;
				end
			end
			ldiag_pkg::ST_PULLUP: begin
				if (pt_abort) begin
					state_d = ldiag_pkg::ST_IDLE;
				end else if (tmr_done) begin
					state_d = ldiag_pkg::ST_PULLDOWN;
				end
			end
			ldiag_pkg::ST_PULLDOWN: begin
				if (pt_abort | tmr_done) begin
					state_d = ldiag_pkg::ST_IDLE;
				end
			end
			default: state_d = ldiag_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q   <= ldiag_pkg::ST_IDLE;
			tmr_q     <= '0;
			pu_open_q <= 3'h0;
		end else begin
			state_q <= state_d;
			if (state_d != state_q) begin
				if (state_d == ldiag_pkg::ST_PULLUP || state_d == ldiag_pkg::ST_PULLDOWN) begin
					tmr_q <= dur_f(hw_mode, dly_sel_q, 1'b0) >> 1;
				end else begin
					tmr_q <= dur_f(hw_mode, dly_sel_q, 1'b1);
				end
			end else if (!tmr_done) begin
				tmr_q <= tmr_q - 1'b1;
			end
			if (state_q == ldiag_pkg::ST_PULLUP && tmr_done) begin
				pu_open_q <= pu_s;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_pend_q <= 1'b0;
			pt_pend_q <= 1'b0;
		end else begin
			if (hw_diag | (wr_ctrl & ~hw_mode & pwdata[ldiag_pkg::CTRL_SH_START])) begin
				sh_pend_q <= 1'b1;
			end else if (state_d == ldiag_pkg::ST_SUPPLY) begin
				sh_pend_q <= 1'b0;
			end
			if (hw_diag | (wr_ctrl & ~hw_mode & pwdata[ldiag_pkg::CTRL_PT_START])) begin
				pt_pend_q <= 1'b1;
			end else if (state_d == ldiag_pkg::ST_PULLUP || (sh_finish && state_q == ldiag_pkg::ST_SUPPLY)
				|| (sh_finish && gnd_s != 3'h0)) begin
				pt_pend_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Active open-load check per phase.
	// ----------------------------------------------------------------
	logic [2:0] act_hit;

	for (genvar g = 0; g < 3; g++) begin : g_act
		logic       armed_q;
		logic       seen_q;
		logic [1:0] cnt_q;
		logic       on;
		logic       evt;

		assign on  = (hw_mode ? ~strap_hi : act_en_q[g]) & (state_q == ldiag_pkg::ST_IDLE);
		assign evt = armed_q & high_side_on[g] & ~seen_q & ~ovs_s[g];
		assign act_hit[g] = on & evt & (cnt_q == FAIL_LAST);

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				armed_q <= 1'b0;
				seen_q  <= 1'b0;
				cnt_q   <= 2'h0;
			end else if (!on) begin
				armed_q <= 1'b0;
				seen_q  <= 1'b0;
				cnt_q   <= 2'h0;
			end else if (low_side_off[g]) begin
				armed_q <= 1'b1;
				seen_q  <= 1'b0;
			end else if (armed_q & high_side_on[g]) begin
				armed_q <= 1'b0;
				cnt_q   <= evt ? ((cnt_q == FAIL_LAST) ? cnt_q : cnt_q + 1'b1) : 2'h0;
			end else if (armed_q & ovs_s[g]) begin
				seen_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Fault flags and thermal handling.
	// ----------------------------------------------------------------
	logic [2:0] ol_flag_q;
	logic [2:0] sup_flag_q;
	logic [2:0] gnd_flag_q;
	logic       therm_flag_q;
	logic       therm_block_q;
	logic       fault_any;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ol_flag_q    <= 3'h0;
			sup_flag_q   <= 3'h0;
			gnd_flag_q   <= 3'h0;
			therm_flag_q <= 1'b0;
		end else begin
			ol_flag_q    <= (ol_flag_q & ~{3{clr}}) | pt_set | act_hit;
			sup_flag_q   <= (sup_flag_q & ~{3{clr}})
				| (sup_s & {3{state_q == ldiag_pkg::ST_SUPPLY && tmr_done}});
			gnd_flag_q   <= (gnd_flag_q & ~{3{clr}})
				| (gnd_s & {3{state_q == ldiag_pkg::ST_GROUND && tmr_done}});
			therm_flag_q <= (therm_flag_q & ~clr) | hot;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			therm_block_q <= 1'b0;
		end else if (hot) begin
			therm_block_q <= 1'b1;
		end else if (auto_eff | clr) begin
			therm_block_q <= 1'b0;
		end
	end

	assign fault_any = (ol_flag_q != 3'h0) | (sup_flag_q != 3'h0) | (gnd_flag_q != 3'h0) | therm_block_q;

	assign rd_mux = (paddr == ldiag_pkg::STAT_OFS) ?
		(32'(therm_block_q) << ldiag_pkg::STAT_BLOCK) | (32'(state_q != ldiag_pkg::ST_IDLE) << ldiag_pkg::STAT_BUSY)
		| (32'(gnd_flag_q) << ldiag_pkg::STAT_GND_LSB) | (32'(sup_flag_q) << ldiag_pkg::STAT_SUP_LSB)
		| (32'(ol_flag_q) << ldiag_pkg::STAT_OL_LSB) | (32'(therm_flag_q) << ldiag_pkg::STAT_THERM)
		| (32'(ol_flag_q != 3'h0) << ldiag_pkg::STAT_OPEN_SUM)
		| (32'(fault_any & ~therm_block_q) << ldiag_pkg::STAT_OPEN_SH)
		| (32'(fault_any | therm_flag_q) << ldiag_pkg::STAT_FAULT) :
		(32'(act_en_q) << ldiag_pkg::CTRL_ACT_LSB) | (32'(dly_sel_q) << ldiag_pkg::CTRL_DLY_LSB)
		| (32'(recov_auto_q) << ldiag_pkg::CTRL_RECOV) | (32'(sh_start_q) << ldiag_pkg::CTRL_SH_START)
		| (32'(pt_start_q) << ldiag_pkg::CTRL_PT_START);

	// ----------------------------------------------------------------
	// Pin outputs.
	// ----------------------------------------------------------------
	logic       fault_n_q;
	logic       gates_off_q;
	logic       cp_en_q;
	logic [2:0] pu_en_q;
	logic [2:0] pd_en_q;
	logic [2:0] dl_en_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_n_q   <= 1'b1;
			gates_off_q <= 1'b1;
			cp_en_q     <= 1'b0;
			pu_en_q     <= 3'h0;
			pd_en_q     <= 3'h0;
			dl_en_q     <= 3'h0;
		end else begin
			fault_n_q   <= ~fault_any;
			gates_off_q <= therm_block_q | ~awake | (state_d != ldiag_pkg::ST_IDLE);
			cp_en_q     <= ~therm_block_q & awake;
			pu_en_q     <= {3{state_d == ldiag_pkg::ST_PULLUP || state_d == ldiag_pkg::ST_GROUND}};
			pd_en_q     <= {3{state_d == ldiag_pkg::ST_PULLDOWN}};
			dl_en_q     <= {3{state_d == ldiag_pkg::ST_SUPPLY}};
		end
	end

	assign fault_out_n       = fault_n_q;
	assign gates_off         = gates_off_q;
	assign charge_pump_en    = cp_en_q;
	assign pullup_src_en     = pu_en_q;
	assign pulldown_src_en   = pd_en_q;
	assign drain_pulldown_en = dl_en_q;

	// ----------------------------------------------------------------
	// Assertions.
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_supply_end;
		state_q == ldiag_pkg::ST_SUPPLY && tmr_done;
	endsequence

	sequence s_pulldown_pass;
		state_q == ldiag_pkg::ST_PULLDOWN && tmr_done && !pt_abort && pt_set == 3'h0 && !wr_ctrl;
	endsequence

	a_fault_pin_low: assert property ((ol_flag_q != 3'h0) |=> !fault_out_n)
		else $error("fault pin not low with open load latched");
	a_start_self_clear: assert property (s_pulldown_pass |=> !pt_start_q ##0 state_q == ldiag_pkg::ST_IDLE)
		else $error("start bit did not return to zero");
	a_gates_off_test: assert property (state_q != ldiag_pkg::ST_IDLE |-> gates_off)
		else $error("transistors not held off during test");
	a_supply_first: assert property ($rose(state_q == ldiag_pkg::ST_GROUND) |-> $past(state_q) == ldiag_pkg::ST_SUPPLY)
		else $error("ground test entered without supply test");
	a_short_skips_pass: assert property (s_supply_end ##0 (sup_s != 3'h0) |=> state_q == ldiag_pkg::ST_IDLE && !pt_pend_q)
		else $error("passive test still pending after short");
	a_active_report: assert property (act_hit[0] |=> ol_flag_q[0] ##1 !fault_out_n)
		else $error("active open load not reported");
	a_pump_on_open: assert property (!therm_block_q && awake && ol_flag_q != 3'h0 |=> charge_pump_en)
		else $error("charge pump stopped on open load");
	a_thermal_auto: assert property (auto_eff && therm_block_q && !hot && !clr |=> !therm_block_q && therm_flag_q)
		else $error("automatic recovery misbehaved");
	a_abort_silent: assert property (pt_abort |=> state_q == ldiag_pkg::ST_IDLE && $stable(ol_flag_q))
		else $error("aborted passive test reported a fault");
	a_pull_order: assert property ($rose(state_q == ldiag_pkg::ST_PULLDOWN) |-> $past(state_q) == ldiag_pkg::ST_PULLUP)
		else $error("pull-down step without pull-up step");
	a_drain_pull: assert property (state_q == ldiag_pkg::ST_SUPPLY |-> drain_pulldown_en == 3'h7)
		else $error("drain pull-downs not enabled in supply test");

endmodule : ldiag_top
`default_nettype wire

// ---- tb_load_and_short_diagnostics.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_load_and_short_diagnostics;
	localparam int D [4] = '{40, 60, 80, 100};
	localparam int HWS   = 50;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, sleep_control_pin;
	logic        hw, diag, therm, pwm, fault_out_n, gates_off, charge_pump_en;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [2:0]  pu, pd, os, sup, gnd, lso, hso, pu_en, pd_en, dr_en;
	logic [10:0] rows [4] = '{{2'h0, 3'h0, 3'h7, 3'h0}, {2'h1, 3'h3, 3'h6, 3'h2},
		{2'h2, 3'h7, 3'h7, 3'h7}, {2'h3, 3'h5, 3'h0, 3'h0}};
	int          err_total, total_checks, npu, npd, ndr, bad;

	ldiag_host host (.pclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr,
		.pwdata, .sleep_control_pin);
	ldiag_top #(.DLY0_CYC(D[0]), .DLY1_CYC(D[1]), .DLY2_CYC(D[2]), .DLY3_CYC(D[3]),
		.HW_SH_CYC(HWS)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .hw_variant_strap(hw), .sleep_control_pin,
		.diag_strap_pin(diag), .thermal_cmp(therm), .pullup_open_comparator(pu),
		.pulldown_open_comparator(pd), .overshoot_cmp(os), .supply_short_cmp(sup),
		.ground_short_cmp(gnd), .low_side_off(lso), .high_side_on(hso), .pwm_input_change(pwm),
		.fault_out_n, .gates_off, .charge_pump_en, .pullup_src_en(pu_en),
		.pulldown_src_en(pd_en), .drain_pulldown_en(dr_en));

	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
		total_checks++;
		if (s !== x) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, s);
		end
	endtask : chk

	task automatic wr(input logic [31:0] v);
		host.xfer(1'b1, ldiag_pkg::CTRL_OFS, v, q, e);
	endtask : wr

	task automatic rd(input logic [11:0] a);
		host.xfer(1'b0, a, 32'h0, q, e);
	endtask : rd

	// Counts source cycles and flags bad order or gates left on.
	task automatic run(input int n);
		npu = 0;
		npd = 0;
		ndr = 0;
		bad = 0;
		repeat (n) begin
			#1;
			if ((pd_en === 3'h7 && npu == 0) || (dr_en === 3'h7 && npu != 0))
				bad++;
			if ((pu_en | pd_en) !== 3'h0 && gates_off !== 1'b1)
				bad++;
			npu += (pu_en === 3'h7);
			npd += (pd_en === 3'h7);
			ndr += (dr_en === 3'h7);
			@(posedge pclk);
		end
	endtask : run

	task automatic dead(input logic o);
		os <= {2'h3, o};
		repeat (4) @(posedge pclk);
		lso <= 3'h1;
		@(posedge pclk);
		lso <= 3'h0;
		repeat (2) @(posedge pclk);
		hso <= 3'h1;
		@(posedge pclk);
		hso <= 3'h0;
		repeat (4) @(posedge pclk);
	endtask : dead

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial begin
		#400000;
		err_total++;
		give_verdict();
	end

	initial begin
		{presetn, hw, diag, therm, pwm, pu, pd, sup, gnd, lso, hso} = '0;
		os = 3'h7;
		err_total = 0;
		total_checks = 0;
		repeat (3) @(posedge pclk);
		chk("reset fault pin", 1, fault_out_n);
		chk("reset pump", 0, charge_pump_en);
		presetn <= 1'b1;
		rd(ldiag_pkg::STAT_OFS);
		chk("status after reset", 0, q);
		rd(12'h008);
		chk("unmapped error", 1, e);
		for (int i = 0; i < 4; i++) begin
			pu <= rows[i][8:6];
			pd <= rows[i][5:3];
			repeat (4) @(posedge pclk);
			wr({26'h0, rows[i][10:9], 4'h1});
			run(D[rows[i][10:9]] + 30);
			chk("pullup cycles", D[rows[i][10:9]] / 2 + 1, npu);
			chk("pulldown cycles", D[rows[i][10:9]] / 2 + 1, npd);
			chk("order and gates", 0, bad);
			rd(ldiag_pkg::STAT_OFS);
			chk("status", {rows[i][2:0], 1'b0, {3{|rows[i][2:0]}}}, q);
			chk("fault pin", ~|rows[i][2:0], fault_out_n);
			chk("pump", 1, charge_pump_en);
			rd(ldiag_pkg::CTRL_OFS);
			chk("start bit", |rows[i][2:0], q[0]);
			if (i[0]) begin
				wr(32'h0);
				host.sleep_pulse(10);
			end else
				wr(32'h4);
			repeat (6) @(posedge pclk);
			rd(ldiag_pkg::STAT_OFS);
			chk("cleared", 0, q);
		end
		for (int i = 0; i < 2; i++) begin
			sup <= i ? 3'h0 : 3'h4;
			gnd <= i ? 3'h1 : 3'h0;
			pu <= 3'h7;
			pd <= 3'h7;
			repeat (4) @(posedge pclk);
			wr(32'h3);
			run(300);
			chk("short order", 0, bad);
			chk("drain pulldowns", 1, ndr > 0);
			chk("no passive", 0, npd);
			rd(ldiag_pkg::STAT_OFS);
			chk("short status", i ? 32'h403 : 32'h203, q);
			wr(32'h4);
		end
		{sup, gnd} <= '0;
		for (int i = 0; i < 2; i++) begin
			wr(32'h31);
			repeat (10) @(posedge pclk);
			if (i == 0) begin
				pwm <= 1'b1;
				@(posedge pclk);
				pwm <= 1'b0;
			end else
				wr(32'h30);
			repeat (6) @(posedge pclk);
			chk("abort sources", 0, pu_en | pd_en);
			rd(ldiag_pkg::STAT_OFS);
			chk("abort status", 0, q);
			rd(ldiag_pkg::CTRL_OFS);
			chk("abort start", 0, q[0]);
		end
		wr(32'h8);
		therm <= 1'b1;
		repeat (6) @(posedge pclk);
		#1;
		chk("hot pin", 0, fault_out_n);
		chk("hot gates", 1, gates_off);
		@(posedge pclk);
		therm <= 1'b0;
		repeat (6) @(posedge pclk);
		#1;
		chk("cool pin", 1, fault_out_n);
		chk("cool gates", 0, gates_off);
		rd(ldiag_pkg::STAT_OFS);
		chk("thermal kept", 1, q[3]);
		wr(32'h4);
		rd(ldiag_pkg::STAT_OFS);
		chk("thermal cleared", 0, q[3]);
		for (int i = 0; i < 3; i++)
			dead(1'b0);
		rd(ldiag_pkg::STAT_OFS);
		chk("active off", 0, q);
		wr(32'h40);
		for (int i = 4; i >= 0; i--)
			dead(i == 2);
		rd(ldiag_pkg::STAT_OFS);
		chk("active count reset", 0, q);
		dead(1'b0);
		rd(ldiag_pkg::STAT_OFS);
		chk("active open", 3'h1, q[6:4]);
		chk("active pin", 0, fault_out_n);
		for (int i = 0; i < 2; i++) begin
			hw <= 1'b1;
			diag <= i[0];
			presetn <= 1'b0;
			repeat (3) @(posedge pclk);
			chk("hw reset pin", 1, fault_out_n);
			presetn <= 1'b1;
			run(250);
			chk("hw supply cycles", i ? 0 : HWS + 1, ndr);
			chk("hw passive cycles", i ? 0 : D[0] / 2 + 1, npd);
			chk("hw order", 0, bad);
			rd(ldiag_pkg::STAT_OFS);
			chk("hw status", i ? 32'h0 : 32'h77, q);
			if (i == 0) begin
				wr(32'h4);
				repeat (3) dead(1'b0);
				rd(ldiag_pkg::STAT_OFS);
				chk("hw active", 3'h1, q[6:4]);
			end
		end
		therm <= 1'b1;
		repeat (6) @(posedge pclk);
		therm <= 1'b0;
		repeat (6) @(posedge pclk);
		#1;
		chk("hw auto gates", 0, gates_off);
		chk("hw auto pin", 1, fault_out_n);
		give_verdict();
	end
endmodule : tb_load_and_short_diagnostics
`default_nettype wire
